// file: src/cdt_regs.svh
/*
 * Register indices, field positions, reset values and timing counts of the countdown timer.
 * Assumes a 32-bit APB bus where each register index stands at byte address four times the index.
 */
`ifndef CDT_REGS_SVH
`define CDT_REGS_SVH

// Register indices; the byte address is four times the index.
`define CDT_IDX_CTRL        6'h14
`define CDT_IDX_RELOAD_HI   6'h15
`define CDT_IDX_RELOAD_LO   6'h16
`define CDT_IDX_COUNT_HI    6'h17
`define CDT_IDX_COUNT_LO    6'h18
`define CDT_IDX_THIRD_CTRL  6'h19
`define CDT_IDX_IRQ_STATUS  6'h20
`define CDT_IDX_IRQ_MASK    6'h21
`define CDT_IDX_COMMAND     6'h22

// Control register fields, shared by both control registers.
`define CDT_F_STOP_RX       7
`define CDT_F_START_HI      5
`define CDT_F_START_LO      4
`define CDT_F_AUTO          3
`define CDT_F_CLK_HI        1
`define CDT_F_CLK_LO        0
`define CDT_CTRL_WMASK      8'hBB

// Interrupt status, mask and command fields.
`define CDT_F_IRQ_UF        0
`define CDT_F_IRQ_RX        1
`define CDT_F_CMD_START     0
`define CDT_F_CMD_STOP      1
`define CDT_F_CMD_RUN       2

// Reset values.
`define CDT_RST_BYTE        8'h00
`define CDT_RST_IRQ         2'h0

// Clock rates in kHz and the derived tick generator constants.
`define CDT_PCLK_KHZ        100000
`define CDT_CARRIER_KHZ     13560
`define CDT_SLOW_DIV        64
`define CDT_PHASE_INC       (`CDT_CARRIER_KHZ / 10)
`define CDT_PHASE_MOD       (`CDT_PCLK_KHZ / 10)

`endif

// file: src/cdt_pkg.sv
/*
 * Types of the countdown timer: start modes, clock selections and run state.
 * Assumes the numeric layout of the control field follows the enumeration order.
 */
package cdt_pkg;

	typedef enum logic [1:0] {CDT_START_MANUAL, CDT_START_AUTO, CDT_START_TRIM, CDT_START_TRIM_UF} cdt_start_t;
	typedef enum logic [1:0] {CDT_CLK_CARRIER, CDT_CLK_SLOW, CDT_CLK_FIRST, CDT_CLK_THIRD} cdt_clk_t;
	typedef enum logic {CDT_IDLE, CDT_RUN} cdt_state_t;

endpackage : cdt_pkg

// file: src/cdt_sync.sv
/*
 * Three-stage synchroniser with agreement filter and rising-edge pulse for an outside pin.
 * Assumes the pin is asynchronous to pclk and changes slowly against it.
 */
`timescale 1ns/10ps
`default_nettype none

module cdt_sync
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin_async,
	output logic      level,
	output logic      rise
);

	logic s1_ff, s2_ff, s3_ff, lvl_ff, rise_ff;
	logic nxt_lvl, nxt_rise;

	// The level only moves when the second and third stages agree.
	always_comb
	begin
		nxt_lvl  = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
		nxt_rise = nxt_lvl & ~lvl_ff;
	end

	// Shift chain and filtered level registers.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_ff   <= 1'b0;
			s2_ff   <= 1'b0;
			s3_ff   <= 1'b0;
			lvl_ff  <= 1'b0;
			rise_ff <= 1'b0;
		end
		else
		begin
			s1_ff   <= pin_async;
			s2_ff   <= s1_ff;
			s3_ff   <= s2_ff;
			lvl_ff  <= nxt_lvl;
			rise_ff <= nxt_rise;
		end
	end

	assign level = lvl_ff;
	assign rise  = rise_ff;

endmodule : cdt_sync

`default_nettype wire

// file: src/cdt_tick.sv
/*
 * Tick generator: carrier-rate and slow-rate enable pulses derived from pclk.
 * Assumes pclk runs at the rate held in the constants header; carrier ticks jitter by one pclk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "cdt_regs.svh"

module cdt_tick
(
	input  wire logic pclk,
	input  wire logic presetn,
	output logic      carrier_tick,
	output logic      slow_tick
);

	localparam logic [13:0] PHASE_INC = 14'(`CDT_PHASE_INC);
	localparam logic [13:0] PHASE_MOD = 14'(`CDT_PHASE_MOD);
	localparam logic [5:0]  SLOW_LAST = 6'(`CDT_SLOW_DIV - 1);

	logic [13:0] phase_ff, nxt_phase;
	logic [5:0]  div_ff, nxt_div;
	logic        car_ff, nxt_car, slow_ff, nxt_slow;
	logic [14:0] sum;

	// Fractional accumulator gives the carrier rate; a counter divides it further.
	always_comb
	begin
		sum       = {1'b0, phase_ff} + {1'b0, PHASE_INC};
		nxt_car   = (sum >= {1'b0, PHASE_MOD});
		nxt_phase = nxt_car ? 14'(sum - {1'b0, PHASE_MOD}) : sum[13:0];
		nxt_div   = div_ff;
		nxt_slow  = 1'b0;
		if (nxt_car)
		begin
			nxt_slow = (div_ff == SLOW_LAST);
			nxt_div  = nxt_slow ? 6'h00 : 6'(div_ff + 6'h01);
		end
	end

	// Accumulator, divider and pulse registers.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_ff <= 14'h0000;
			div_ff   <= 6'h00;
			car_ff   <= 1'b0;
			slow_ff  <= 1'b0;
		end
		else
		begin
			phase_ff <= nxt_phase;
			div_ff   <= nxt_div;
			car_ff   <= nxt_car;
			slow_ff  <= nxt_slow;
		end
	end

	assign carrier_tick = car_ff;
	assign slow_tick    = slow_ff;

endmodule : cdt_tick

`default_nettype wire

// file: src/cdt_timer1.sv
/*
 * Cascadable 16-bit countdown timer with APB register file and interrupt.
 * Assumes the transmit-end, receive-nibble and sibling underflow inputs are one-cycle pulses on pclk,
 * and that the oscillator trimming input is an asynchronous pin.
 */
`timescale 1ns/10ps
`default_nettype none
`include "cdt_regs.svh"

// Behaviour
// - Stop-on-receive halts timer after first nibble
// - Stop-on-receive ignored in oscillator trimming modes
// - Start mode 00 manual, 01 at transmit end
// - Modes 10/11 trim oscillator, pin edge start/stop
// - Auto-restart reloads and continues at zero, except in start mode 10
// - Without auto-restart count stops at zero
// - Every underflow sets the interrupt flag
// - Clock select 00 carrier, 01 slow divided clock
// - Clock select 10/11 cascade sibling underflows
// - Reload bytes at 15h/16h load on start
// - Reload writes wait for the next start
// - Live count readable at 17h and 18h
// - Third timer control at 19h, same layout
module cdt_timer1
	import cdt_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        tx_end,
	input  wire logic        rx_nibble_done,
	input  wire logic        first_sibling_underflow,
	input  wire logic        third_sibling_underflow,
	input  wire logic        low_freq_oscillator,
	output logic             irq,
	output logic             timer1_underflow,
	output logic             timer1_running,
	output logic             third_stop_on_receive,
	output logic      [1:0]  third_start_mode,
	output logic             third_auto_restart,
	output logic      [1:0]  third_clock_select
);

	logic [7:0]  ctrl_ff, third_ff, rel_hi_ff, rel_lo_ff;
	logic [7:0]  nxt_ctrl, nxt_third, nxt_rel_hi, nxt_rel_lo;
	logic [1:0]  mask_ff, stat_ff, nxt_mask, nxt_stat;
	logic [15:0] cnt_ff, nxt_cnt;
	cdt_state_t  state_ff, nxt_state;
	logic        uf_ff, nxt_uf;
	logic [31:0] rdata_ff, nxt_rdata;

	logic        carrier_tick, slow_tick, osc_rise;
	logic        setup, access, wr, rd, hit;
	logic [5:0]  idx;
	logic [15:0] reload_value;
	cdt_start_t  start_mode;
	cdt_clk_t    clock_select;
	logic        stop_on_receive, auto_restart, trim, running;
	logic        tick, cmd_start, cmd_stop, start_ev, stop_ev, rx_stop, underflow, st_read;

	// Rate enables for the carrier and the divided clock.
	cdt_tick i_cdt_tick
	(
		.pclk         (pclk),
		.presetn      (presetn),
		.carrier_tick (carrier_tick),
		.slow_tick    (slow_tick)
	);

	// Oscillator trimming pin, synchronised and edge detected.
	cdt_sync i_cdt_sync
	(
		.pclk      (pclk),
		.presetn   (presetn),
		.pin_async (low_freq_oscillator),
		.level     (),
		.rise      (osc_rise)
	);

	// Bus phases and address decode; unaligned or unknown addresses fail.
	always_comb
	begin
		setup  = psel & ~penable;
		access = psel & penable;
		wr     = access & pwrite;
		rd     = access & ~pwrite;
		idx    = paddr[7:2];
		hit    = (paddr[1:0] == 2'b00) &&
			(((idx >= `CDT_IDX_CTRL) && (idx <= `CDT_IDX_THIRD_CTRL)) ||
			((idx >= `CDT_IDX_IRQ_STATUS) && (idx <= `CDT_IDX_COMMAND)));
	end

	assign pready  = 1'b1;
	assign pslverr = access & ~hit;

	// Control field views.
	always_comb
	begin
		stop_on_receive = ctrl_ff[`CDT_F_STOP_RX];
		start_mode      = cdt_start_t'(ctrl_ff[`CDT_F_START_HI:`CDT_F_START_LO]);
		auto_restart    = ctrl_ff[`CDT_F_AUTO];
		clock_select    = cdt_clk_t'(ctrl_ff[`CDT_F_CLK_HI:`CDT_F_CLK_LO]);
		trim            = (start_mode == CDT_START_TRIM) || (start_mode == CDT_START_TRIM_UF);
		running         = (state_ff == CDT_RUN);
		reload_value    = {rel_hi_ff, rel_lo_ff};
	end

	// Input clock selection.
	always_comb
	begin
		unique case (clock_select)
			CDT_CLK_CARRIER: tick = carrier_tick;
			CDT_CLK_SLOW:    tick = slow_tick;
			CDT_CLK_FIRST:   tick = first_sibling_underflow;
			CDT_CLK_THIRD:   tick = third_sibling_underflow;
		endcase
	end

	// Start and stop events.
	always_comb
	begin
		cmd_start = wr && hit && (idx == `CDT_IDX_COMMAND) && pwdata[`CDT_F_CMD_START];
		cmd_stop  = wr && hit && (idx == `CDT_IDX_COMMAND) && pwdata[`CDT_F_CMD_STOP];
		rx_stop   = running && rx_nibble_done && stop_on_receive && !trim;
		start_ev  = cmd_start ||
			((start_mode == CDT_START_AUTO) && tx_end) ||
			(trim && osc_rise && !running);
		stop_ev   = cmd_stop || rx_stop || (trim && osc_rise && running);
		underflow = running && tick && (cnt_ff == 16'h0000) &&
			(start_mode != CDT_START_TRIM) && !start_ev && !stop_ev;
	end

	// Counter and run state; a start wins over a stop in the same cycle.
	always_comb
	begin
		nxt_cnt   = cnt_ff;
		nxt_state = state_ff;
		nxt_uf    = 1'b0;
		if (start_ev)
		begin
			nxt_cnt   = reload_value;
			nxt_state = CDT_RUN;
		end
		else if (stop_ev)
		begin
			nxt_state = CDT_IDLE;
		end
		else if (underflow)
		begin
			nxt_uf = 1'b1;
			if (auto_restart)
			begin
				nxt_cnt = reload_value;
			end
			else
			begin
				nxt_state = CDT_IDLE;
			end
		end
		else if (running && tick && (cnt_ff != 16'h0000))
		begin
			nxt_cnt = 16'(cnt_ff - 16'h0001);
		end
	end

	// Register writes; a status read clears, but a new event in that cycle still sets.
	always_comb
	begin
		nxt_ctrl   = ctrl_ff;
		nxt_third  = third_ff;
		nxt_rel_hi = rel_hi_ff;
		nxt_rel_lo = rel_lo_ff;
		nxt_mask   = mask_ff;
		st_read    = rd && hit && (idx == `CDT_IDX_IRQ_STATUS);
		if (wr && hit)
		begin
			unique case (idx)
				`CDT_IDX_CTRL:       nxt_ctrl   = pwdata[7:0] & `CDT_CTRL_WMASK;
				`CDT_IDX_THIRD_CTRL: nxt_third  = pwdata[7:0] & `CDT_CTRL_WMASK;
				`CDT_IDX_RELOAD_HI:  nxt_rel_hi = pwdata[7:0];
				`CDT_IDX_RELOAD_LO:  nxt_rel_lo = pwdata[7:0];
				`CDT_IDX_IRQ_MASK:   nxt_mask   = pwdata[1:0];
				default:             nxt_mask   = mask_ff;
			endcase
		end
		nxt_stat = st_read ? (stat_ff & ~rdata_ff[1:0]) : stat_ff;             // Clears only what the read returned.
		nxt_stat[`CDT_F_IRQ_UF] = nxt_stat[`CDT_F_IRQ_UF] | underflow;
		nxt_stat[`CDT_F_IRQ_RX] = nxt_stat[`CDT_F_IRQ_RX] | (rx_stop & !start_ev);
	end

	// Read data is captured in the setup phase and held through the access phase.
	always_comb
	begin
		nxt_rdata = rdata_ff;
		if (setup)
		begin
			nxt_rdata = 32'h0000_0000;
			if (!pwrite && hit)
			begin
				unique case (idx)
					`CDT_IDX_CTRL:       nxt_rdata[7:0] = ctrl_ff;
					`CDT_IDX_RELOAD_HI:  nxt_rdata[7:0] = rel_hi_ff;
					`CDT_IDX_RELOAD_LO:  nxt_rdata[7:0] = rel_lo_ff;
					`CDT_IDX_COUNT_HI:   nxt_rdata[7:0] = cnt_ff[15:8];
					`CDT_IDX_COUNT_LO:   nxt_rdata[7:0] = cnt_ff[7:0];
					`CDT_IDX_THIRD_CTRL: nxt_rdata[7:0] = third_ff;
					`CDT_IDX_IRQ_STATUS: nxt_rdata[1:0] = stat_ff;
					`CDT_IDX_IRQ_MASK:   nxt_rdata[1:0] = mask_ff;
					default:             nxt_rdata[`CDT_F_CMD_RUN] = running;
				endcase
			end
		end
	end

	// State registers.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_ff   <= `CDT_RST_BYTE;
			third_ff  <= `CDT_RST_BYTE;
			rel_hi_ff <= `CDT_RST_BYTE;
			rel_lo_ff <= `CDT_RST_BYTE;
			mask_ff   <= `CDT_RST_IRQ;
			stat_ff   <= `CDT_RST_IRQ;
			cnt_ff    <= 16'h0000;
			state_ff  <= CDT_IDLE;
			uf_ff     <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
		end
		else
		begin
			ctrl_ff   <= nxt_ctrl;
			third_ff  <= nxt_third;
			rel_hi_ff <= nxt_rel_hi;
			rel_lo_ff <= nxt_rel_lo;
			mask_ff   <= nxt_mask;
			stat_ff   <= nxt_stat;
			cnt_ff    <= nxt_cnt;
			state_ff  <= nxt_state;
			uf_ff     <= nxt_uf;
			rdata_ff  <= nxt_rdata;
		end
	end

	// Outputs.
	assign prdata                = rdata_ff;
	assign irq                   = |(stat_ff & mask_ff);
	assign timer1_underflow      = uf_ff;
	assign timer1_running        = running;
	assign third_stop_on_receive = third_ff[`CDT_F_STOP_RX];
	assign third_start_mode      = third_ff[`CDT_F_START_HI:`CDT_F_START_LO];
	assign third_auto_restart    = third_ff[`CDT_F_AUTO];
	assign third_clock_select    = third_ff[`CDT_F_CLK_HI:`CDT_F_CLK_LO];

	// Checks on the counter, events and register file.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_ctrl_read_setup;
		setup && !pwrite && (paddr == {`CDT_IDX_CTRL, 2'b00});
	endsequence

	sequence s_access_ok;
		access && !pslverr && (prdata[6] == 1'b0) && (prdata[2] == 1'b0);
	endsequence

	property p_rx_stop;
		rx_stop && !start_ev |=> !timer1_running;
	endproperty
	a_rx_stop: assert property (p_rx_stop) else $error("Receive did not stop the timer.");

	property p_trim_ignores_rx;
		running && trim && rx_nibble_done && !stop_ev && !underflow |=> timer1_running;
	endproperty
	a_trim_ignores_rx: assert property (p_trim_ignores_rx) else $error("Receive stopped a trimming timer.");

	property p_auto_start;
		(start_mode == CDT_START_AUTO) && tx_end |=> timer1_running && (cnt_ff == $past(reload_value));
	endproperty
	a_auto_start: assert property (p_auto_start) else $error("Transmit end did not load and start.");

	property p_trim_edge;
		trim && osc_rise && !cmd_start |=> (timer1_running != $past(running));
	endproperty
	a_trim_edge: assert property (p_trim_edge) else $error("Trimming edge did not toggle the run state.");

	property p_restart;
		underflow && auto_restart |=> timer1_running && (cnt_ff == $past(reload_value));
	endproperty
	a_restart: assert property (p_restart) else $error("Auto restart did not reload.");

	property p_stop_zero;
		underflow && !auto_restart |=> !timer1_running && (cnt_ff == 16'h0000);
	endproperty
	a_stop_zero: assert property (p_stop_zero) else $error("Counter did not stop at zero.");

	// The pulse may only stay high when a second underflow followed at once.
	property p_uf_flag;
		underflow |=> stat_ff[`CDT_F_IRQ_UF] && timer1_underflow ##1 (!timer1_underflow || $past(underflow));
	endproperty
	a_uf_flag: assert property (p_uf_flag) else $error("Underflow did not set its flag.");

	property p_decrement;
		running && tick && (cnt_ff != 16'h0000) && !start_ev && !stop_ev |=> cnt_ff == 16'($past(cnt_ff) - 16'h0001);
	endproperty
	a_decrement: assert property (p_decrement) else $error("Counter did not step down by one.");

	property p_reload_quiet;
		wr && ((idx == `CDT_IDX_RELOAD_HI) || (idx == `CDT_IDX_RELOAD_LO)) && !tick && !start_ev
			|=> cnt_ff == $past(cnt_ff);
	endproperty
	a_reload_quiet: assert property (p_reload_quiet) else $error("Reload write disturbed the count.");

	property p_reserved_zero;
		s_ctrl_read_setup ##1 access |-> s_access_ok;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved control bits read nonzero.");

	property p_manual_only_cmd;
		(start_mode == CDT_START_MANUAL) && !running && !cmd_start |=> !timer1_running;
	endproperty
	a_manual_only_cmd: assert property (p_manual_only_cmd) else $error("Manual mode started without a command.");

	property p_idle_hold;
		!running && !start_ev |=> (cnt_ff == $past(cnt_ff)) && !timer1_underflow;
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("Idle counter moved or underflowed.");

	property p_tick_select;
		running && (clock_select == CDT_CLK_FIRST) && !first_sibling_underflow && !start_ev |=> cnt_ff == $past(cnt_ff);
	endproperty
	a_tick_select: assert property (p_tick_select) else $error("Counter moved without its selected tick.");

endmodule : cdt_timer1

`default_nettype wire

// file: test/tb_cdt_timer1.sv
/*
 * Self-checking bench of the cascadable countdown timer: registers, start modes, cascade, trim and interrupt.
 * Assumes the design answers APB with zero wait states and samples event pulses on pclk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "cdt_regs.svh"

module tb_cdt_timer1;
	localparam logic [7:0] A_CTRL = {`CDT_IDX_CTRL, 2'b00};
	localparam logic [7:0] A_RHI  = {`CDT_IDX_RELOAD_HI, 2'b00};
	localparam logic [7:0] A_RLO  = {`CDT_IDX_RELOAD_LO, 2'b00};
	localparam logic [7:0] A_CHI  = {`CDT_IDX_COUNT_HI, 2'b00};
	localparam logic [7:0] A_CLO  = {`CDT_IDX_COUNT_LO, 2'b00};
	localparam logic [7:0] A_T3   = {`CDT_IDX_THIRD_CTRL, 2'b00};
	localparam logic [7:0] A_ST   = {`CDT_IDX_IRQ_STATUS, 2'b00};
	localparam logic [7:0] A_MSK  = {`CDT_IDX_IRQ_MASK, 2'b00};
	localparam logic [7:0] A_CMD  = {`CDT_IDX_COMMAND, 2'b00};
	localparam logic [7:0] A_RST [6] = '{A_CTRL, A_RHI, A_RLO, A_CHI, A_CLO, A_T3};
	localparam int         WD_CYCLES = 40000;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, r;
	logic        tx_end, rx_nibble_done, first_sibling_underflow, third_sibling_underflow;
	logic        low_freq_oscillator, irq, timer1_underflow, timer1_running, t3_stop, t3_auto;
	logic [1:0]  t3_start, t3_clk;
	logic [15:0] v, rl;
	logic [31:0] rng = 32'h0000002C;
	int          bad_count, n_compared, p, n_uf;

	cdt_timer1 i_cdt_timer1 (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_end(tx_end),
		.rx_nibble_done(rx_nibble_done), .first_sibling_underflow(first_sibling_underflow),
		.third_sibling_underflow(third_sibling_underflow), .low_freq_oscillator(low_freq_oscillator), .irq(irq),
		.timer1_underflow(timer1_underflow), .timer1_running(timer1_running), .third_stop_on_receive(t3_stop),
		.third_start_mode(t3_start), .third_auto_restart(t3_auto), .third_clock_select(t3_clk));

	// Free-running 100 MHz clock.
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Xorshift source of repeatable random values.
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs

	// Count expected after p ticks from a start with reload value rl.
	function automatic logic [15:0] exp_cnt(input logic [15:0] rl, input int p, input logic au);
		if (p <= rl)
			return rl - 16'(p);
		return au ? rl - 16'(p % (rl + 1)) : 16'h0000;
	endfunction : exp_cnt

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One APB transfer; read data and error are taken at the edge where pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask : rdc

	// Reads the live count as two bytes; only used while no ticks arrive.
	task automatic cnt();
		apb(1'b0, A_CHI, 32'h0);
		v[15:8] = rd[7:0];
		apb(1'b0, A_CLO, 32'h0);
		v[7:0] = rd[7:0];
	endtask : cnt

	// Pulses event k (0 first sibling, 1 third sibling, 2 transmit end, 3 receive nibble) n times.
	task automatic pulse(input int k, input int n);
		repeat (n)
		begin
			@(posedge pclk);
			{first_sibling_underflow, third_sibling_underflow, tx_end, rx_nibble_done} <= 4'h8 >> k;
			@(posedge pclk);
			{first_sibling_underflow, third_sibling_underflow, tx_end, rx_nibble_done} <= 4'h0;
			@(posedge pclk);
		end
	endtask : pulse

	// One rising edge of the oscillator pin, long enough to pass the synchroniser.
	task automatic osc_edge();
		@(posedge pclk);
		low_freq_oscillator <= 1'b1;
		repeat (10) @(posedge pclk);
		low_freq_oscillator <= 1'b0;
		repeat (10) @(posedge pclk);
	endtask : osc_edge

	task automatic end_sim();
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	// Counts underflow pulses; each one stands for exactly one cycle.
	always @(posedge pclk)
	begin
		if (timer1_underflow === 1'b1)
			n_uf++;
	end

	// Cuts a hang short.
	initial
	begin
		repeat (WD_CYCLES) @(posedge pclk);
		bad_count++;
		end_sim();
	end

	// Main sequence.
	initial
	begin
		{presetn, psel, penable, pwrite, tx_end, rx_nibble_done} = 6'h00;
		{first_sibling_underflow, third_sibling_underflow, low_freq_oscillator} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		foreach (A_RST[i])
			rdc("reset value", A_RST[i], 32'h0);
		apb(1'b1, A_CTRL, 32'hFF);
		rdc("control reserved", A_CTRL, 32'hBB);
		r = xs() & 32'hFF;
		apb(1'b1, A_T3, r);
		rdc("third control", A_T3, r & 32'hBB);
		chk("third fields", {r[7], r[5:4], r[3], r[1:0]}, {t3_stop, t3_start, t3_auto, t3_clk});
		apb(1'b1, A_CHI, 32'h5A);
		rdc("count read only", A_CHI, 32'h0);
		apb(1'b1, 8'hFC, 32'h1);
		chk("unmapped error", 1, err);
		r = xs() & 32'hFFFF;
		apb(1'b1, A_RHI, r >> 8);
		apb(1'b1, A_RLO, r & 32'hFF);
		rdc("reload high", A_RHI, r >> 8);
		rdc("reload low", A_RLO, r & 32'hFF);
		$display("test registers done");
		// Cascade from either sibling, with and without auto-restart and interrupt mask.
		for (int i = 0; i < 4; i++)
		begin
			rl = 16'(xs() % 8 + 1);
			p = int'(rl) + 1 + int'(xs() % 4);
			apb(1'b1, A_MSK, 32'(i % 2 == 0));
			apb(1'b1, A_CTRL, 32'h02 | (i & 1) | ((i & 2) << 2));
			apb(1'b1, A_RHI, 32'h0);
			apb(1'b1, A_RLO, 32'(rl));
			apb(1'b1, A_CMD, 32'h1);
			n_uf = 0;
			pulse(1 - (i & 1), 2);
			pulse(i & 1, p);
			cnt();
			chk("cascade count", exp_cnt(rl, p, i[1]), v);
			chk("running", i[1], timer1_running);
			chk("underflow pulses", i[1] ? p / (rl + 1) : 1, n_uf);
			chk("irq level", 32'(i % 2 == 0), irq);
			rdc("underflow flag", A_ST, 32'h1);
			@(posedge pclk);
			chk("irq cleared", 0, irq);
			apb(1'b1, A_CMD, 32'h2);
		end
		$display("test cascade done");
		apb(1'b1, A_CTRL, 32'h02);
		apb(1'b1, A_RLO, 32'h05);
		apb(1'b1, A_CMD, 32'h1);
		apb(1'b1, A_RLO, 32'h33);
		pulse(0, 2);
		cnt();
		chk("reload kept", 16'h0003, v);
		apb(1'b1, A_CMD, 32'h1);
		cnt();
		chk("reload on start", 16'h0033, v);
		apb(1'b1, A_CMD, 32'h2);
		pulse(2, 1);
		chk("manual ignores tx end", 0, timer1_running);
		apb(1'b1, A_CTRL, 32'h12);
		pulse(2, 1);
		chk("auto start", 1, timer1_running);
		pulse(3, 1);
		chk("receive no stop", 1, timer1_running);
		apb(1'b1, A_CTRL, 32'h92);
		pulse(3, 1);
		chk("receive stop", 0, timer1_running);
		$display("test start modes done");
		apb(1'b1, A_CTRL, 32'hB2);
		apb(1'b1, A_RLO, 32'h0);
		osc_edge();
		chk("trim start", 1, timer1_running);
		pulse(3, 1);
		chk("trim ignores receive", 1, timer1_running);
		osc_edge();
		chk("trim stop", 0, timer1_running);
		apb(1'b1, A_ST, 32'h0);
		apb(1'b0, A_ST, 32'h0);
		osc_edge();
		pulse(0, 1);
		apb(1'b0, A_ST, 32'h0);
		chk("trim underflow", 1, rd[0]);
		apb(1'b1, A_CTRL, 32'hA2);
		apb(1'b1, A_CMD, 32'h2);
		osc_edge();
		pulse(0, 1);
		apb(1'b0, A_ST, 32'h0);
		chk("trim no underflow", 0, rd[0]);
		$display("test trim done");
		// Rate of the carrier and the slow clock over fixed spans of 1000 and 6400 cycles.
		for (int i = 0; i < 2; i++)
		begin
			apb(1'b1, A_CMD, 32'h2);
			apb(1'b1, A_CTRL, 32'(i));
			apb(1'b1, A_RHI, 32'hFF);
			apb(1'b1, A_RLO, 32'hFF);
			apb(1'b1, A_CMD, 32'h1);
			repeat (i ? 6400 : 1000) @(posedge pclk);
			apb(1'b1, A_CMD, 32'h2);
			cnt();
			v = 16'hFFFF - v;
			chk("tick rate", 1, i ? (v >= 12 && v <= 15) : (v >= 133 && v <= 138));
		end
		$display("test clock rates done");
		end_sim();
	end
endmodule : tb_cdt_timer1
`default_nettype wire
